// ### rtl/byte_op_and_branch_exec.sv
/*
  Execution unit for clearing the accumulator, stepping a file register
  (with or without a skip on zero), absolute branching and OR of a
  literal into the accumulator. Holds the accumulator, the zero flag
  and the program counter.
  Assumes the fetch stage presents one instruction word with its file
  operand already read, on the same clock, and honours instr_ready_o.
  After a flush cycle the fetcher resumes at pc_o; a skipped word is
  never retired here, it is simply refused for one cycle. The file
  write port is one-shot: the register file must take it on the
  cycle that we is high.
*/
`timescale 1ns/10ps

module byte_op_and_branch_exec (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 instr_valid_i,
  input  wire exec_pkg::instr_t     instr_i,
  input  wire logic [7:0]           pc_upper_latch_i,
  output logic                      instr_ready_o,
  output logic      [7:0]           acc_o,
  output logic                      zero_flag_o,
  output logic      [12:0]          pc_o,
  output exec_pkg::file_wr_t        file_wr_o,
  output logic                      retire_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  exec_pkg::op_t     op;
  logic              dest_sel;
  logic [6:0]        faddr;
  logic [7:0]        literal_value;
  logic [10:0]       branch_k;
  logic [7:0]        step_result;
  logic              step_zero;
  logic              step_down;
  logic [7:0]        or_result;
  logic [12:0]       branch_target;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------

  // Field slices and carriers are laid out for these exact widths;
  // a package edit that changes one must revisit the decode
  if (exec_pkg::WORD_W != 14) begin : g_word_bad
    $error("instruction word must be 14 bits");
  end
  if (exec_pkg::DATA_W != 8) begin : g_data_bad
    $error("data path must be 8 bits");
  end
  if (exec_pkg::PC_W != exec_pkg::K11_W + 2) begin : g_pc_bad
    $error("program counter must be branch field plus two");
  end
  if (exec_pkg::FADDR_W >= exec_pkg::DEST_BIT + 1) begin : g_faddr_bad
    $error("file address overlaps the destination bit");
  end
  if (exec_pkg::LATCH_HI_BIT != exec_pkg::LATCH_LO_BIT + 1) begin : g_lat_bad
    $error("latch bits must be adjacent");
  end
  if (exec_pkg::K11_W >= exec_pkg::WORD_W) begin : g_k_bad
    $error("branch field does not fit the word");
  end

  // Patterns are disjoint, so order only matters for readability
  // Unknown words fall to OP_NONE: taken, PC steps, nothing else
  always_comb begin
    if ((instr_i.word & exec_pkg::CLR_ACC_MASK) ==
        exec_pkg::CLR_ACC_VAL) begin
      op = exec_pkg::OP_CLR_ACC;
    end else if ((instr_i.word & exec_pkg::DEC_F_MASK) ==
                 exec_pkg::DEC_F_VAL) begin
      op = exec_pkg::OP_DEC_F;
    end else if ((instr_i.word & exec_pkg::DEC_SKIP_MASK) ==
                 exec_pkg::DEC_SKIP_VAL) begin
      op = exec_pkg::OP_DEC_SKIP;
    end else if ((instr_i.word & exec_pkg::INC_SKIP_MASK) ==
                 exec_pkg::INC_SKIP_VAL) begin
      op = exec_pkg::OP_INC_SKIP;
    end else if ((instr_i.word & exec_pkg::BRANCH_MASK) ==
                 exec_pkg::BRANCH_VAL) begin
      op = exec_pkg::OP_BRANCH;
    end else if ((instr_i.word & exec_pkg::OR_LIT_MASK) ==
                 exec_pkg::OR_LIT_VAL) begin
      op = exec_pkg::OP_OR_LIT;
    end else begin
      op = exec_pkg::OP_NONE;
    end
  end

  // Operand fields
  // Low seven bits name the file; bit 7 picks the destination
  assign dest_sel      = instr_i.word[exec_pkg::DEST_BIT];
  assign faddr         = instr_i.word[exec_pkg::FADDR_W-1:0];
  assign literal_value = instr_i.word[exec_pkg::DATA_W-1:0];
  assign branch_k      = instr_i.word[exec_pkg::K11_W-1:0];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------

  // Only the increment-and-skip form counts upward
  assign step_down = (op != exec_pkg::OP_INC_SKIP);

  operand_stepper u_stepper (
    .operand_i   (instr_i.operand),
    .step_down_i (step_down),
    .result_o    (step_result),
    .is_zero_o   (step_zero)
  );

  exec_pkg::exec_state_t st_reg;
  exec_pkg::exec_state_t st_next;

  assign or_result = st_reg.acc | literal_value;

  // Upper two bits come from the latch, never from the old PC
  assign branch_target = {pc_upper_latch_i[exec_pkg::LATCH_HI_BIT],
                          pc_upper_latch_i[exec_pkg::LATCH_LO_BIT],
                          branch_k};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // A flush cycle stands in for the discarded or refetched word
  always_comb begin
    st_next            = st_reg;
    st_next.retire     = 1'b0;
    st_next.file_wr.we = 1'b0;
    if (st_reg.flush) begin
      // The word offered now is refused; PC and flags stay
      st_next.flush = 1'b0;
    end else if (instr_valid_i) begin
      st_next.retire = 1'b1;
      // Plain step, wrapping at the top; a branch overrides it below
      st_next.pc     = 13'(st_reg.pc + exec_pkg::PC_STEP);
      case (op)
        exec_pkg::OP_CLR_ACC: begin
          st_next.acc       = exec_pkg::DATA_ZERO;
          st_next.zero_flag = 1'b1;
        end
        exec_pkg::OP_DEC_F,
        exec_pkg::OP_DEC_SKIP,
        exec_pkg::OP_INC_SKIP: begin
          if (dest_sel == exec_pkg::DEST_ACC) begin
            st_next.acc = step_result;
          end else begin
            st_next.file_wr.we   = 1'b1;
            st_next.file_wr.addr = faddr;
            st_next.file_wr.data = step_result;
          end
          if (op == exec_pkg::OP_DEC_F) begin
            st_next.zero_flag = step_zero;
          end
          // Skip forms leave the flag alone and skip only on zero
          if (op != exec_pkg::OP_DEC_F && step_zero) begin
            st_next.flush = 1'b1;
          // Nonzero result: no flush, the next word runs
          end
        end
        exec_pkg::OP_BRANCH: begin
          st_next.pc    = branch_target;
          st_next.flush = 1'b1;
        end
        exec_pkg::OP_OR_LIT: begin
          st_next.acc       = or_result;
          st_next.zero_flag = (or_result == exec_pkg::DATA_ZERO);
        end
        default: begin
          // Words outside this block's set only advance the PC and retire
          st_next.flush = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Synchronous reset to a known idle state
  // Write port address and data clear too, so no stale value shows
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_reg.acc          <= exec_pkg::ACC_RESET;
      st_reg.zero_flag    <= 1'b0;
      st_reg.pc           <= exec_pkg::PC_RESET;
      st_reg.flush        <= 1'b0;
      st_reg.retire       <= 1'b0;
      st_reg.file_wr.we   <= 1'b0;
      st_reg.file_wr.addr <= 7'h00;
      st_reg.file_wr.data <= exec_pkg::DATA_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Ready drops for the second cycle of a skip or a branch
  assign instr_ready_o = ~st_reg.flush;
  // The rest are plain register copies, no logic on the way out
  assign acc_o         = st_reg.acc;
  assign zero_flag_o   = st_reg.zero_flag;
  assign pc_o          = st_reg.pc;
  assign file_wr_o     = st_reg.file_wr;
  assign retire_o      = st_reg.retire;

endmodule

// ### rtl/exec_pkg.sv
/*
  Shared constants and types for the byte-operation and branch
  execution block: opcode patterns, field positions, reset values,
  the instruction carrier, the file write carrier and the state record.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W  = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W    = 13;
  localparam int unsigned K11_W   = 11;

  // ----------------------------------------------------------------
  // Opcode patterns (mask, then value)
  // ----------------------------------------------------------------
  localparam logic [13:0] CLR_ACC_MASK  = 14'h3f80;
  localparam logic [13:0] CLR_ACC_VAL   = 14'h0100;
  localparam logic [13:0] DEC_F_MASK    = 14'h3f00;
  localparam logic [13:0] DEC_F_VAL     = 14'h0300;
  localparam logic [13:0] DEC_SKIP_MASK = 14'h3f00;
  localparam logic [13:0] DEC_SKIP_VAL  = 14'h0b00;
  localparam logic [13:0] INC_SKIP_MASK = 14'h3f00;
  localparam logic [13:0] INC_SKIP_VAL  = 14'h0f00;
  localparam logic [13:0] BRANCH_MASK   = 14'h3800;
  localparam logic [13:0] BRANCH_VAL    = 14'h2800;
  localparam logic [13:0] OR_LIT_MASK   = 14'h3f00;
  localparam logic [13:0] OR_LIT_VAL    = 14'h3800;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned DEST_BIT      = 7;
  localparam int unsigned LATCH_HI_BIT  = 4;
  localparam int unsigned LATCH_LO_BIT  = 3;
  localparam logic        DEST_ACC      = 1'b0;
  localparam logic        DEST_FILE     = 1'b1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [12:0] PC_STEP       = 13'h0001;
  localparam logic [7:0]  DATA_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_CLR_ACC   = 3'b001,
    OP_DEC_F     = 3'b010,
    OP_DEC_SKIP  = 3'b011,
    OP_INC_SKIP  = 3'b100,
    OP_BRANCH    = 3'b101,
    OP_OR_LIT    = 3'b110
  } op_t;

  typedef struct packed {
    logic [13:0] word;
    logic [7:0]  operand;
  } instr_t;

  typedef struct packed {
    logic        we;
    logic [6:0]  addr;
    logic [7:0]  data;
  } file_wr_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic        zero_flag;
    logic [12:0] pc;
    logic        flush;
    logic        retire;
    file_wr_t    file_wr;
  } exec_state_t;

endpackage

// ### rtl/operand_stepper.sv
/*
  Eight-bit step unit: adds or subtracts one and flags a zero result.
  Purely combinational; the caller registers whatever it keeps.
*/
`timescale 1ns/10ps

module operand_stepper (
  input  wire logic [7:0] operand_i,
  input  wire logic       step_down_i,
  output logic      [7:0] result_o,
  output logic            is_zero_o
);

  // ----------------------------------------------------------------
  // Step and zero detect
  // ----------------------------------------------------------------

  // Wraps modulo 256 in both directions
  always_comb begin
    if (step_down_i) begin
      result_o = 8'(operand_i - 8'h01);
    end else begin
      result_o = 8'(operand_i + 8'h01);
    end
    is_zero_o = (result_o == exec_pkg::DATA_ZERO);
  end

endmodule

// ### tb/byte_op_and_branch_exec_chk.sv
/*
  Port checker for the execution block.
  Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/10ps
module byte_op_and_branch_exec_chk (
  input wire logic               core_clk_i,
  input wire logic               reset_i,
  input wire logic               instr_valid_i,
  input wire exec_pkg::instr_t   instr_i,
  input wire logic [7:0]         pc_upper_latch_i,
  input wire logic               instr_ready_o,
  input wire logic [7:0]         acc_o,
  input wire logic               zero_flag_o,
  input wire logic [12:0]        pc_o,
  input wire exec_pkg::file_wr_t file_wr_o,
  input wire logic               retire_o
);
  // Decode of the word taken at this edge
  wire [13:0] w = instr_i.word;
  wire [7:0] op = instr_i.operand;
  wire tk = instr_valid_i && instr_ready_o && !reset_i;
  wire clr = tk && (w & 14'h3f80) == 14'h0100;
  wire dcf = tk && (w & 14'h3f00) == 14'h0300;
  wire dsk = tk && (w & 14'h3f00) == 14'h0b00;
  wire isk = tk && (w & 14'h3f00) == 14'h0f00;
  wire br = tk && (w & 14'h3800) == 14'h2800;
  wire orl = tk && (w & 14'h3f00) == 14'h3800;
  wire zsk = (dsk && op == 8'h01) || (isk && op == 8'hff);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_clear_sets_zero: assert property (
    $past(clr) |-> acc_o == 8'h00 && zero_flag_o) else $error("clear");
  a_branch_pc_load: assert property (
    $past(br) |-> pc_o == {$past(pc_upper_latch_i[4:3]), $past(w[10:0])}
      && !instr_ready_o && $stable(zero_flag_o)) else $error("branch");
  a_skip_flag_kept: assert property (
    $past(dsk || isk) |-> $stable(zero_flag_o)) else $error("skip flag");
  a_skip_zero_flush: assert property (
    $past(zsk) |-> !instr_ready_o) else $error("no skip");
  a_nonzero_no_flush: assert property (
    $past((dsk || isk) && !zsk) |-> instr_ready_o) else $error("skip");
  a_flush_single: assert property (
    !instr_ready_o |=> instr_ready_o) else $error("long flush");
  a_or_literal: assert property (
    $past(orl) |-> acc_o == ($past(acc_o) | $past(w[7:0]))
      && zero_flag_o == (acc_o == 8'h00)) else $error("or");
  a_dec_to_file: assert property (
    $past(dcf && w[7]) |-> file_wr_o.we && file_wr_o.addr == $past(w[6:0])
      && file_wr_o.data == $past(op) - 8'h01) else $error("dec file");
  a_dec_to_acc: assert property (
    $past(dcf && !w[7]) |-> !file_wr_o.we && acc_o == $past(op) - 8'h01
      && zero_flag_o == (acc_o == 8'h00)) else $error("dec acc");
  a_dec_file_zero: assert property (
    $past(dcf && w[7]) |-> zero_flag_o == (file_wr_o.data == 8'h00))
    else $error("dec zero");
  a_skip_to_acc: assert property (
    $past((dsk || isk) && !w[7]) |-> !file_wr_o.we
      && acc_o == 8'($past(op) + ($past(isk) ? 8'h01 : 8'hff)))
    else $error("skip acc");
  a_pc_advance: assert property (
    $past(tk && !br) |-> pc_o == 13'($past(pc_o) + 13'h0001))
    else $error("pc step");
  a_refused_hold: assert property (
    !instr_ready_o |=> $stable(pc_o) && $stable(acc_o)) else $error("nop");
  a_retire_pulse: assert property (
    retire_o == $past(tk)) else $error("retire");
endmodule
bind byte_op_and_branch_exec byte_op_and_branch_exec_chk i_chk (
  .core_clk_i, .reset_i, .instr_valid_i, .instr_i, .pc_upper_latch_i,
  .instr_ready_o, .acc_o, .zero_flag_o, .pc_o, .file_wr_o, .retire_o);

// ### tb/byte_op_and_branch_exec_tb.sv
/*
  Random self-checking bench for the execution block.
  Assumes a one-cycle answer and one flush cycle per skip or branch.
*/
`timescale 1ns/10ps
module byte_op_and_branch_exec_tb;
  logic               core_clk_i, reset_i, instr_valid_i, instr_ready_o;
  logic               zero_flag_o, retire_o, mz, mfl, mwe, mret;
  logic [7:0]         lat, acc_o, macc, mdata, res;
  logic [6:0]         maddr;
  logic [12:0]        pc_o, mpc;
  exec_pkg::instr_t   instr_i;
  exec_pkg::file_wr_t file_wr_o;
  logic [31:0]        seed = 32'h00009167;
  logic [13:0]        base [7] = '{14'h0100, 14'h0300, 14'h0b00,
                                   14'h0f00, 14'h2800, 14'h3800, 14'h0000};
  logic [13:0]        msk [7] = '{14'h007f, 14'h00ff, 14'h00ff,
                                  14'h00ff, 14'h07ff, 14'h00ff, 14'h007f};
  int                 fail_count = 0, samples_checked = 0, cyc = 0, t;

  byte_op_and_branch_exec i_dut (
    .core_clk_i, .reset_i, .instr_valid_i, .instr_i,
    .pc_upper_latch_i(lat), .instr_ready_o, .acc_o, .zero_flag_o,
    .pc_o, .file_wr_o, .retire_o);

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checked %0d bad %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reference model: state expected after the coming edge
  task automatic step;
    mwe = 1'b0;
    mret = 1'b0;
    if (reset_i) begin
      {macc, mz, mpc, mfl, maddr, mdata} = '0;
    end else if (mfl) mfl = 1'b0; // Refused word is the no-op
    else if (instr_valid_i) begin
      mret = 1'b1;
      mpc = mpc + 13'h0001;
      res = instr_i.operand + ((t == 3) ? 8'h01 : 8'hff);
      case (t)
        0: {macc, mz} = {8'h00, 1'b1};
        4: {mpc, mfl} = {lat[4:3], instr_i.word[10:0], 1'b1};
        6: ; // Foreign word: PC step and retire only
        5: begin
          macc |= instr_i.word[7:0];
          mz = macc == 8'h00;
        end
        default: begin
          if (instr_i.word[7]) begin
            {mwe, maddr, mdata} = {1'b1, instr_i.word[6:0], res};
          end else macc = res;
          if (t == 1) mz = res == 8'h00;
          else mfl = res == 8'h00;
        end
      endcase
    end
  endtask

  // Hang guard: well above the 3000 cycles of the run
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end

  // Drive at the falling edge; a second reset lands mid-run
  initial begin
    reset_i = 1'b1;
    instr_valid_i = 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk_i);
      if (i > 0) begin
        cmp(16'(acc_o), 16'(macc));
        cmp(16'(zero_flag_o), 16'(mz));
        cmp(16'(pc_o), 16'(mpc));
        cmp(16'(instr_ready_o), 16'(!mfl));
        cmp(16'(file_wr_o.we), 16'(mwe));
        if (mwe) cmp(16'(file_wr_o.data), 16'(mdata));
        if (mwe) cmp(16'(file_wr_o.addr), 16'(maddr));
        cmp(16'(retire_o), 16'(mret));
      end
      seed = xs(seed);
      reset_i = (i < 7) || (i >= 1500 && i < 1503);
      t = seed[2:0] % 7;
      instr_valid_i = seed[5:3] != 3'h0;
      lat = seed[15:8];
      instr_i.operand = seed[17] ? seed[31:24] : (seed[16] ? 8'hff : 8'h01);
      instr_i.word = base[t] | (seed[31:18] & msk[t]);
      step();
    end
    conclude();
  end
endmodule
